// file: rtl/fapp_pkg.sv
// constants, register map and state type of the flash array controller
// Functional notes
// - every erased byte reads back as 0xFF
// - programming only clears bits; a zero never returns to one
// - no single-byte erase; ones come back only by erasing the page
// - array is 16 kB as 32 pages of 512 bytes; page erase clears all
// - two erase scopes: one selected page, or the whole array at once
// - verify command compares a stored byte with the data byte
// - protection setup is read from bytes at the top of page 31
// - four bytes give one write/erase guard bit per page
// - one byte gives read guard, each bit covering four pages
// - one byte holds the key needed to change protection
// - once protection is set, page 31 is always write/erase guarded
// - last six bytes of page 31 are reserved, user gets 506 bytes
// - 1 write, 2 erase page, 3 erase all, 4 read, 5 erase+write, 8 protect
// - commands run only with unlock key 0x3B; key resets after each command
// - command write stalls the core until done; interrupts deferred
// - protection change needs key match at 0x3FFA; 0xFF skips; key set once
package fapp_pkg;

   // ***********************************************
   // array geometry
   // ***********************************************
   localparam int ADDR_W = 14;
   localparam int PAGE_W = 5;
   localparam int OFFS_W = 9;
   localparam int DEPTH = 16384;
   localparam logic [7:0] ERASED_BYTE = 8'hFF;
   localparam logic [8:0] PAGE_END_OFFS = 9'h1FF;
   localparam logic [13:0] LAST_ADDR = 14'h3FFF;
   localparam logic [13:0] ARRAY_BASE = 14'h0000;

   // ***********************************************
   // protection bytes in the last page
   // ***********************************************
   localparam logic [13:0] PROT_BASE = 14'h3FFA;
   localparam logic [2:0] PROT_IDX_KEY = 3'h0;
   localparam logic [2:0] PROT_IDX_RP = 3'h1;
   localparam logic [2:0] PROT_IDX_WP = 3'h2;
   localparam logic [2:0] PROT_IDX_LAST = 3'h5;
   localparam logic [4:0] PROT_PAGE = 5'h1F;

   // ***********************************************
   // command codes and keys
   // ***********************************************
   localparam logic [7:0] CMD_WRITE = 8'h01;
   localparam logic [7:0] CMD_ERASE_PAGE = 8'h02;
   localparam logic [7:0] CMD_ERASE_ALL = 8'h03;
   localparam logic [7:0] CMD_READ = 8'h04;
   localparam logic [7:0] CMD_ERASE_WRITE = 8'h05;
   localparam logic [7:0] CMD_VERIFY = 8'h06;
   localparam logic [7:0] CMD_PROTECT = 8'h08;
   localparam logic [7:0] UNLOCK_CODE = 8'h3B;
   localparam logic [7:0] KEY_RST = 8'hFF;
   localparam logic [7:0] NO_KEY = 8'hFF;
   localparam logic [7:0] BYTE_RST = 8'h00;
   localparam logic [31:0] WP_RST = 32'hFFFFFFFF;

   // ***********************************************
   // register byte offsets on the bus
   // ***********************************************
   localparam logic [7:0] OFS_CMD = 8'h00;
   localparam logic [7:0] OFS_DATA = 8'h04;
   localparam logic [7:0] OFS_ADDR_LO = 8'h08;
   localparam logic [7:0] OFS_ADDR_HI = 8'h0C;
   localparam logic [7:0] OFS_UNLOCK = 8'h10;
   localparam logic [7:0] OFS_PROT_KEY = 8'h14;
   localparam logic [7:0] OFS_WP_STAGE = 8'h18;
   localparam logic [7:0] OFS_RP_STAGE = 8'h1C;
   localparam logic [7:0] OFS_STATUS = 8'h20;
   localparam logic [7:0] OFS_WP_ACTIVE = 8'h24;
   localparam logic [7:0] OFS_PROT_INFO = 8'h28;

   // status bit positions
   localparam int ST_BUSY = 0;
   localparam int ST_KEY_ERR = 1;
   localparam int ST_PROT_ERR = 2;
   localparam int ST_VFY_FAIL = 3;
   localparam int ST_BAD_CMD = 4;

   // controller states, gray in the order listed, not along the transitions taken
   typedef enum logic [3:0] {
      S_IDLE = 4'h0,
      S_ERASE = 4'h1,
      S_RMW_RD = 4'h3,
      S_RMW_WR = 4'h2,
      S_RD_ISSUE = 4'h6,
      S_RD_TAKE = 4'h7,
      S_LOAD_RD = 4'h5,
      S_LOAD_TK = 4'h4
   } fapp_state_type;

endpackage

// file: rtl/fapp_mem_if.sv
// byte port between the flash controller and its storage array
`timescale 1ns/10ps
interface fapp_mem_if;
   logic en;
   logic we;
   logic [13:0] addr;
   logic [7:0] wdata;
   logic [7:0] rdata;
   modport ctrl (output en, output we, output addr, output wdata,
                 input rdata);
   modport mem (input en, input we, input addr, input wdata,
                output rdata);
endinterface

// file: rtl/fapp_array.sv
// byte-wide storage array with registered read data
`timescale 1ns/10ps
module fapp_array (
   input wire logic core_clk,
   fapp_mem_if.mem port
);
   import fapp_pkg::*;

   // power-up contents model a blank, erased part; no second writer process
   logic [7:0] cell_r [0:DEPTH-1] = '{default: ERASED_BYTE};
   logic [7:0] rdata_r;

   // one access per cycle; read data appears the cycle after the request
   always_ff @(posedge core_clk) begin
      if (port.en && port.we) begin
         cell_r[port.addr] <= port.wdata;
      end
      if (port.en) begin
         rdata_r <= cell_r[port.addr];
      end
   end

   assign port.rdata = rdata_r;

endmodule

// file: rtl/fapp_ctrl.sv
// flash array controller: apb registers, commands, erase and protection
//
// Design decisions made here: the APB register port and the placing of the registers.
`timescale 1ns/10ps
module fapp_ctrl (
   input wire logic core_clk,
   input wire logic sys_rst,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   output logic irq_defer
);
   import fapp_pkg::*;

   // ***********************************************
   // decode helpers
   // ***********************************************

   // page number of a byte address
   function automatic logic [4:0] page_of(input logic [13:0] a);
      page_of = a[13:9];
   endfunction

   // bytes kept for protection data are closed to the write and erase+write commands
   function automatic logic is_reserved(input logic [13:0] a);
      is_reserved = (a >= PROT_BASE);
   endfunction

   function automatic logic is_mapped(input logic [7:0] a);
      case (a)
         OFS_CMD, OFS_DATA, OFS_ADDR_LO, OFS_ADDR_HI, OFS_UNLOCK,
         OFS_PROT_KEY, OFS_WP_STAGE, OFS_RP_STAGE, OFS_STATUS,
         OFS_WP_ACTIVE, OFS_PROT_INFO: is_mapped = 1'b1;
         default: is_mapped = 1'b0;
      endcase
   endfunction

   // ***********************************************
   // state
   // ***********************************************
   fapp_mem_if mem ();

   fapp_state_type state_r;
   logic [7:0] cmd_r;
   logic [7:0] data_r;
   logic [7:0] addr_lo_r;
   logic [5:0] addr_hi_r;
   logic [7:0] unlock_r;
   logic [7:0] prot_key_r;
   logic [31:0] wp_stage_r;
   logic [7:0] rp_stage_r;
   logic [13:0] ptr_r;
   logic [2:0] idx_r;
   logic cmd_held_r;
   logic [7:0] key_sh_r;
   logic [7:0] rp_sh_r;
   logic [31:0] wp_sh_r;
   logic key_err_r;
   logic prot_err_r;
   logic vfy_fail_r;
   logic bad_cmd_r;
   logic [31:0] prdata_r;

   logic [13:0] addr_w;
   logic [4:0] page_w;
   logic configured;
   logic [31:0] wp_eff;
   logic wp_hit;
   logic rp_hit;
   logic key_ok;
   logic prot_ok;
   logic cmd_acc;
   logic start;
   logic done;
   logic wr_en;
   fapp_state_type dec_state;
   logic [13:0] dec_ptr;
   logic dec_prot_err;
   logic dec_bad;
   logic [7:0] prog_byte;
   logic [31:0] rd_mux;

   assign addr_w = {addr_hi_r, addr_lo_r};
   assign page_w = page_of(addr_w);

   // any programmed protection byte means protection is in force
   assign configured = ({key_sh_r, rp_sh_r, wp_sh_r} != {6{ERASED_BYTE}});

   // a cleared guard bit protects its page; page 31 joins in once set
   always_comb begin
      wp_eff = wp_sh_r;
      if (configured) begin
         wp_eff[PROT_PAGE] = 1'b0;
      end
   end

   assign wp_hit = !wp_eff[page_w];
   assign rp_hit = !rp_sh_r[page_w[4:2]];
   assign key_ok = (unlock_r == UNLOCK_CODE);
   // a blank stored key waives the comparison
   assign prot_ok = (key_sh_r == NO_KEY) || (prot_key_r == key_sh_r);

   // ***********************************************
   // apb handshake
   // ***********************************************
   assign cmd_acc = psel && penable && pwrite && (paddr == OFS_CMD);
   // the command write stalls in its access phase until the array is idle
   assign start = cmd_acc && !cmd_held_r && (state_r == S_IDLE);
   assign done = cmd_acc && cmd_held_r && (state_r == S_IDLE);
   assign pready = cmd_acc ? done : 1'b1;
   assign pslverr = psel && penable && !is_mapped(paddr);
   assign wr_en = psel && penable && pwrite && pready && is_mapped(paddr);
   // core holds interrupts while the array is busy on its command
   assign irq_defer = cmd_held_r;
   assign prdata = prdata_r;

   // ***********************************************
   // command decode
   // ***********************************************

   // first state and pointer of a command, or the reason it is refused
   always_comb begin
      dec_state = S_IDLE;
      dec_ptr = addr_w;
      dec_prot_err = 1'b0;
      dec_bad = 1'b0;
      case (pwdata[7:0])
         CMD_WRITE: begin
            dec_prot_err = wp_hit || is_reserved(addr_w);
            dec_state = S_RMW_RD;
         end
         CMD_ERASE_PAGE: begin
            dec_prot_err = wp_hit;
            dec_state = S_ERASE;
            dec_ptr = {page_w, {OFFS_W{1'b0}}};
         end
         CMD_ERASE_ALL: begin
            dec_prot_err = !prot_ok;
            dec_state = S_ERASE;
            dec_ptr = ARRAY_BASE;
         end
         CMD_READ, CMD_VERIFY: begin
            dec_prot_err = rp_hit;
            dec_state = S_RD_ISSUE;
         end
         CMD_ERASE_WRITE: begin
            dec_prot_err = wp_hit || is_reserved(addr_w);
            dec_state = S_ERASE;
            dec_ptr = {page_w, {OFFS_W{1'b0}}};
         end
         CMD_PROTECT: begin
            dec_prot_err = !prot_ok;
            dec_state = S_RMW_RD;
            dec_ptr = PROT_BASE;
         end
         default: begin
            dec_bad = 1'b1;
         end
      endcase
   end

   // byte to program: the data byte, or one protection byte in turn
   always_comb begin
      prog_byte = data_r;
      if (cmd_r == CMD_PROTECT) begin
         case (idx_r)
            // the key is laid down only while the stored key is blank
            PROT_IDX_KEY: prog_byte = (key_sh_r == NO_KEY) ?
                                      prot_key_r : ERASED_BYTE;
            PROT_IDX_RP: prog_byte = rp_stage_r;
            3'h2: prog_byte = wp_stage_r[7:0];
            3'h3: prog_byte = wp_stage_r[15:8];
            3'h4: prog_byte = wp_stage_r[23:16];
            // setting protection always guards the protection page too
            3'h5: prog_byte = {1'b0, wp_stage_r[30:24]};
            default: prog_byte = ERASED_BYTE;
         endcase
      end
   end

   // ***********************************************
   // array port
   // ***********************************************
   always_comb begin
      mem.en = 1'b0;
      mem.we = 1'b0;
      mem.addr = ptr_r;
      mem.wdata = ERASED_BYTE;
      case (state_r)
         S_ERASE: begin
            mem.en = 1'b1;
            mem.we = 1'b1;
            mem.wdata = ERASED_BYTE;
         end
         S_RMW_RD, S_RD_ISSUE: begin
            mem.en = 1'b1;
         end
         S_RMW_WR: begin
            mem.en = 1'b1;
            mem.we = 1'b1;
            // merging with the old byte means bits can only fall
            mem.wdata = mem.rdata & prog_byte;
         end
         S_LOAD_RD: begin
            mem.en = 1'b1;
            mem.addr = PROT_BASE + {11'h000, idx_r};
         end
         default: begin
            mem.en = 1'b0;
         end
      endcase
   end

   fapp_array u_array (
      .core_clk(core_clk),
      .port(mem.mem)
   );

   // ***********************************************
   // sequencer
   // ***********************************************

   // after reset and after each array change the protection is reloaded
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         state_r <= S_LOAD_RD;
         ptr_r <= ARRAY_BASE;
         idx_r <= PROT_IDX_KEY;
      end else begin
         case (state_r)
            S_IDLE: begin
               if (start && key_ok && !dec_prot_err && !dec_bad) begin
                  state_r <= dec_state;
                  ptr_r <= dec_ptr;
                  idx_r <= PROT_IDX_KEY;
               end
            end
            S_ERASE: begin
               if ((cmd_r == CMD_ERASE_ALL) ? (ptr_r == LAST_ADDR) :
                   (ptr_r[8:0] == PAGE_END_OFFS)) begin
                  if (cmd_r == CMD_ERASE_WRITE) begin
                     state_r <= S_RMW_RD;
                     ptr_r <= addr_w;
                  end else begin
                     state_r <= S_LOAD_RD;
                     idx_r <= PROT_IDX_KEY;
                  end
               end else begin
                  ptr_r <= ptr_r + 14'h0001;
               end
            end
            S_RMW_RD: begin
               state_r <= S_RMW_WR;
            end
            S_RMW_WR: begin
               if ((cmd_r == CMD_PROTECT) && (idx_r != PROT_IDX_LAST)) begin
                  state_r <= S_RMW_RD;
                  ptr_r <= ptr_r + 14'h0001;
                  idx_r <= idx_r + 3'h1;
               end else begin
                  state_r <= S_LOAD_RD;
                  idx_r <= PROT_IDX_KEY;
               end
            end
            S_RD_ISSUE: begin
               state_r <= S_RD_TAKE;
            end
            S_RD_TAKE: begin
               state_r <= S_IDLE;
            end
            S_LOAD_RD: begin
               state_r <= S_LOAD_TK;
            end
            S_LOAD_TK: begin
               if (idx_r == PROT_IDX_LAST) begin
                  state_r <= S_IDLE;
               end else begin
                  state_r <= S_LOAD_RD;
                  idx_r <= idx_r + 3'h1;
               end
            end
            default: begin
               state_r <= S_IDLE;
            end
         endcase
      end
   end

   // protection shadows, all unguarded until the stored bytes are read
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         key_sh_r <= NO_KEY;
         rp_sh_r <= ERASED_BYTE;
         wp_sh_r <= WP_RST;
      end else if (state_r == S_LOAD_TK) begin
         case (idx_r)
            PROT_IDX_KEY: key_sh_r <= mem.rdata;
            PROT_IDX_RP: rp_sh_r <= mem.rdata;
            3'h2: wp_sh_r[7:0] <= mem.rdata;
            3'h3: wp_sh_r[15:8] <= mem.rdata;
            3'h4: wp_sh_r[23:16] <= mem.rdata;
            3'h5: wp_sh_r[31:24] <= mem.rdata;
            default: key_sh_r <= key_sh_r;
         endcase
      end
   end

   // the command stays held from its start until its transfer completes
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         cmd_held_r <= 1'b0;
         cmd_r <= BYTE_RST;
      end else if (start) begin
         cmd_held_r <= 1'b1;
         cmd_r <= pwdata[7:0];
      end else if (done) begin
         cmd_held_r <= 1'b0;
      end
   end

   // outcome flags describe the latest command only
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         key_err_r <= 1'b0;
         prot_err_r <= 1'b0;
         bad_cmd_r <= 1'b0;
         vfy_fail_r <= 1'b0;
      end else if (start) begin
         key_err_r <= !key_ok;
         prot_err_r <= key_ok && dec_prot_err;
         bad_cmd_r <= key_ok && dec_bad;
         vfy_fail_r <= 1'b0;
      end else if ((state_r == S_RD_TAKE) && (cmd_r == CMD_VERIFY)) begin
         vfy_fail_r <= (mem.rdata != data_r);
      end
   end

   // ***********************************************
   // software registers
   // ***********************************************

   // data byte: read command result wins over a software write
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         data_r <= BYTE_RST;
      end else if ((state_r == S_RD_TAKE) && (cmd_r == CMD_READ)) begin
         data_r <= mem.rdata;
      end else if (wr_en && (paddr == OFS_DATA)) begin
         data_r <= pwdata[7:0];
      end
   end

   // unlock key is spent by every command so a runaway loop cannot reuse it
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         unlock_r <= KEY_RST;
      end else if (wr_en && (paddr == OFS_UNLOCK)) begin
         unlock_r <= pwdata[7:0];
      end else if (done) begin
         unlock_r <= KEY_RST;
      end
   end

   // address, protection key and staged protection values
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         addr_lo_r <= BYTE_RST;
         addr_hi_r <= BYTE_RST[5:0];
         prot_key_r <= KEY_RST;
         wp_stage_r <= WP_RST;
         rp_stage_r <= ERASED_BYTE;
      end else if (wr_en) begin
         case (paddr)
            OFS_ADDR_LO: addr_lo_r <= pwdata[7:0];
            OFS_ADDR_HI: addr_hi_r <= pwdata[5:0];
            OFS_PROT_KEY: prot_key_r <= pwdata[7:0];
            OFS_WP_STAGE: wp_stage_r <= pwdata;
            OFS_RP_STAGE: rp_stage_r <= pwdata[7:0];
            default: prot_key_r <= prot_key_r;
         endcase
      end
   end

   // read view; unused upper bits read as zero
   always_comb begin
      rd_mux = 32'h00000000;
      case (paddr)
         OFS_CMD: rd_mux[7:0] = cmd_r;
         OFS_DATA: rd_mux[7:0] = data_r;
         OFS_ADDR_LO: rd_mux[7:0] = addr_lo_r;
         OFS_ADDR_HI: rd_mux[5:0] = addr_hi_r;
         OFS_UNLOCK: rd_mux[7:0] = unlock_r;
         OFS_PROT_KEY: rd_mux[7:0] = prot_key_r;
         OFS_WP_STAGE: rd_mux = wp_stage_r;
         OFS_RP_STAGE: rd_mux[7:0] = rp_stage_r;
         OFS_STATUS: begin
            rd_mux[ST_BUSY] = (state_r != S_IDLE);
            rd_mux[ST_KEY_ERR] = key_err_r;
            rd_mux[ST_PROT_ERR] = prot_err_r;
            rd_mux[ST_VFY_FAIL] = vfy_fail_r;
            rd_mux[ST_BAD_CMD] = bad_cmd_r;
         end
         OFS_WP_ACTIVE: rd_mux = wp_eff;
         OFS_PROT_INFO: rd_mux[15:0] = {key_sh_r, rp_sh_r};
         default: rd_mux = 32'h00000000;
      endcase
   end

   // read data is sampled in the setup phase and held through access
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         prdata_r <= 32'h00000000;
      end else if (psel && !penable && !pwrite) begin
         prdata_r <= rd_mux;
      end
   end

endmodule

// file: tb/fapp_checker.sv
// bus-pin assertions for the flash array controller
`timescale 1ns/10ps
module fapp_checker
   import fapp_pkg::*;
(
   input wire logic core_clk,
   input wire logic sys_rst,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic irq_defer
);
   // ***********************************************
   // helper state
   // ***********************************************
   logic key_ok_r;
   logic [15:0] wait_r;
   logic acc;
   logic cmd_wr;

   // access phase and command write decode
   assign acc = psel && penable;
   assign cmd_wr = psel && pwrite && paddr == OFS_CMD;

   // unlock key seen by the bus; dropped when any command completes
   always_ff @(posedge core_clk) begin
      if (sys_rst)
         key_ok_r <= 1'b0;
      else if (acc && pready && pwrite && paddr == OFS_UNLOCK)
         key_ok_r <= pwdata[7:0] == UNLOCK_CODE;
      else if (acc && pready && cmd_wr)
         key_ok_r <= 1'b0;
   end

   // wait states of the running access; a counter, since erase all is long
   always_ff @(posedge core_clk) begin
      if (sys_rst || !acc || pready)
         wait_r <= 16'h0000;
      else
         wait_r <= wait_r + 16'h0001;
   end

   default clocking @(posedge core_clk); endclocking
   default disable iff (sys_rst);

   // ***********************************************
   // assertions
   // ***********************************************
   a_err_unmapped: assert property (
      acc && paddr > OFS_PROT_INFO |-> pslverr)
      else $error("unmapped access without error");
   a_ok_mapped: assert property (
      acc && paddr <= OFS_PROT_INFO && paddr[1:0] == 2'b00 |-> !pslverr)
      else $error("mapped access flagged as error");
   a_fast_regs: assert property (
      acc && paddr != OFS_CMD |-> pready)
      else $error("plain register access stalled");
   a_read_nowait: assert property (
      acc && !pwrite |-> pready)
      else $error("read access stalled");
   a_defer_start: assert property (
      acc && cmd_wr && wait_r == 16'h0000 && !pready |=> irq_defer)
      else $error("interrupts not deferred during command");
   a_defer_only: assert property (
      irq_defer |-> acc && cmd_wr)
      else $error("interrupts deferred outside a command");
   a_defer_ends: assert property (
      irq_defer && pready |=> !irq_defer)
      else $error("deferral outlives the command");
   a_keyless_quick: assert property (
      psel && !penable && cmd_wr && !key_ok_r |=> !pready ##1 pready)
      else $error("command without key not refused at once");
   a_stall_bound: assert property (
      wait_r < 16'h4080)
      else $error("command stall too long");
   a_prdata_held: assert property (
      psel && pwrite |=> $stable(prdata))
      else $error("read data changed by a write");
endmodule

bind fapp_ctrl fapp_checker chk (.core_clk(core_clk), .sys_rst(sys_rst),
   .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
   .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
   .irq_defer(irq_defer));

// file: tb/fapp_cpu_model.sv
// processor-side bus master that issues flash register accesses
`timescale 1ns/10ps
module fapp_cpu_model (
   input wire logic core_clk,
   output logic psel,
   output logic penable,
   output logic pwrite,
   output logic [7:0] paddr,
   output logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr
);
   // idle bus from time zero
   initial begin
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h00000000;
   end

   // one transfer; request held until pready, then an idle cycle follows
   // so that no signal is assigned twice in one time step
   task automatic xfer(input logic w, input logic [7:0] a,
                       input logic [31:0] d, output logic [31:0] q,
                       output logic e);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge core_clk);
      penable <= 1'b1;
      // no cycle budget here: only the bench watchdog ends a stuck wait
      do begin
         @(posedge core_clk);
      end while (pready !== 1'b1);
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge core_clk);
   endtask
endmodule

// file: tb/testbench.sv
// self-checking bench for the flash array controller
`timescale 1ns/10ps
module testbench;
   import fapp_pkg::*;
   logic core_clk, sys_rst, psel, penable, pwrite, pready, pslverr, e;
   logic irq_defer;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, q;
   int num_errors, checks;

   fapp_cpu_model cpu (.core_clk(core_clk), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr));
   fapp_ctrl uut (.core_clk(core_clk), .sys_rst(sys_rst), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .irq_defer(irq_defer));

   // ***********************************************
   // helpers
   // ***********************************************
   always #12.5 core_clk = ~core_clk;

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp) begin
         num_errors++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      cpu.xfer(1'b1, a, d, q, e);
   endtask
   task automatic ck_rd(input logic [7:0] a, input logic [31:0] exp);
      cpu.xfer(1'b0, a, 32'h00000000, q, e);
      chk(q, exp);
   endtask
   // key goes in right before each command, as software must do
   task automatic cmd(input logic [7:0] c, input logic [13:0] a,
                      input logic [7:0] d);
      wr(OFS_ADDR_LO, {24'h000000, a[7:0]});
      wr(OFS_ADDR_HI, {26'h0000000, a[13:8]});
      wr(OFS_DATA, {24'h000000, d});
      wr(OFS_UNLOCK, {24'h000000, UNLOCK_CODE});
      wr(OFS_CMD, {24'h000000, c});
   endtask
   task automatic ck_st(input logic [4:0] exp);
      ck_rd(OFS_STATUS, {27'h0000000, exp});
   endtask
   task automatic ck_byte(input logic [13:0] a, input logic [7:0] exp);
      cmd(CMD_READ, a, 8'h00);
      ck_rd(OFS_DATA, {24'h000000, exp});
   endtask

   // ***********************************************
   // scenarios; later ones reuse the pages of earlier ones
   // ***********************************************
   task automatic t_reset;
      ck_rd(OFS_UNLOCK, 32'h000000FF);
      ck_rd(OFS_WP_ACTIVE, 32'hFFFFFFFF);
      ck_rd(OFS_PROT_INFO, 32'h0000FFFF);
      cpu.xfer(1'b0, 8'h40, 32'h00000000, q, e);
      chk({31'h00000000, e}, 32'h00000001);
      ck_byte(14'h0000, 8'hFF);
      $display("test reset done");
   endtask

   task automatic t_key;
      wr(OFS_CMD, {24'h000000, CMD_WRITE});
      ck_st(5'h02);
      wr(OFS_UNLOCK, 32'h0000003A);
      wr(OFS_CMD, {24'h000000, CMD_WRITE});
      ck_st(5'h02);
      ck_rd(OFS_UNLOCK, 32'h000000FF);
      ck_byte(14'h0000, 8'hFF);
      $display("test key done");
   endtask

   task automatic t_program;
      cmd(CMD_WRITE, 14'h0203, 8'h5A);
      ck_st(5'h00);
      ck_rd(OFS_UNLOCK, 32'h000000FF);
      ck_byte(14'h0203, 8'h5A);
      cmd(CMD_WRITE, 14'h0203, 8'hF0);
      ck_byte(14'h0203, 8'h50);
      cmd(CMD_VERIFY, 14'h0203, 8'h50);
      ck_st(5'h00);
      cmd(CMD_VERIFY, 14'h0203, 8'h51);
      ck_st(5'h08);
      cmd(8'h07, 14'h0203, 8'h00);
      ck_st(5'h10);
      $display("test program done");
   endtask

   task automatic t_erase;
      cmd(CMD_WRITE, 14'h0400, 8'h11);
      cmd(CMD_ERASE_PAGE, 14'h03FF, 8'h00);
      ck_byte(14'h0203, 8'hFF);
      ck_byte(14'h0400, 8'h11);
      cmd(CMD_WRITE, 14'h0205, 8'h0F);
      cmd(CMD_ERASE_WRITE, 14'h0203, 8'hC3);
      ck_byte(14'h0203, 8'hC3);
      ck_byte(14'h0205, 8'hFF);
      cmd(CMD_WRITE, 14'h3FFA, 8'h00);
      ck_st(5'h04);
      ck_rd(OFS_PROT_INFO, 32'h0000FFFF);
      cmd(CMD_WRITE, 14'h3FF9, 8'hA5);
      ck_byte(14'h3FF9, 8'hA5);
      cmd(CMD_ERASE_ALL, 14'h0000, 8'h00);
      ck_byte(14'h0400, 8'hFF);
      ck_byte(14'h3FF9, 8'hFF);
      $display("test erase done");
   endtask

   task automatic t_protect;
      cmd(CMD_WRITE, 14'h0400, 8'h11);
      wr(OFS_PROT_KEY, 32'h00000077);
      wr(OFS_WP_STAGE, 32'hFFFFFFFB);
      wr(OFS_RP_STAGE, 32'h000000FD);
      cmd(CMD_PROTECT, 14'h0000, 8'h00);
      ck_rd(OFS_WP_ACTIVE, 32'h7FFFFFFB);
      ck_rd(OFS_PROT_INFO, 32'h000077FD);
      cmd(CMD_ERASE_PAGE, 14'h0400, 8'h00);
      ck_st(5'h04);
      ck_byte(14'h0400, 8'h11);
      cmd(CMD_WRITE, 14'h0600, 8'h00);
      ck_st(5'h00);
      cmd(CMD_READ, 14'h0800, 8'h00);
      ck_st(5'h04);
      cmd(CMD_READ, 14'h0FFF, 8'h00);
      ck_st(5'h04);
      cmd(CMD_READ, 14'h1000, 8'h00);
      ck_st(5'h00);
      cmd(CMD_WRITE, 14'h3E00, 8'h00);
      ck_st(5'h04);
      wr(OFS_PROT_KEY, 32'h00000012);
      cmd(CMD_PROTECT, 14'h0000, 8'h00);
      ck_st(5'h04);
      cmd(CMD_ERASE_ALL, 14'h0000, 8'h00);
      ck_st(5'h04);
      wr(OFS_PROT_KEY, 32'h00000077);
      wr(OFS_WP_STAGE, 32'hFFFFFFF7);
      cmd(CMD_PROTECT, 14'h0000, 8'h00);
      ck_st(5'h00);
      ck_rd(OFS_WP_ACTIVE, 32'h7FFFFFF3);
      $display("test protect done");
   endtask

   // ***********************************************
   // run control
   // ***********************************************
   task automatic wrap_up;
      $display("checks %0d num_errors %0d", checks, num_errors);
      if (num_errors == 0 && checks > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask

   // reset, let the protection bytes load, then the scenarios
   initial begin
      core_clk = 1'b0;
      sys_rst = 1'b1;
      num_errors = 0;
      checks = 0;
      repeat (3) @(posedge core_clk);
      sys_rst <= 1'b0;
      repeat (14) @(posedge core_clk);
      t_reset();
      t_key();
      t_program();
      t_erase();
      t_protect();
      wrap_up();
   end

   // hang guard, about four times the expected run
   initial begin
      #2000000;
      num_errors++;
      $display("Error at %0t: watchdog expired", $time);
      wrap_up();
   end
endmodule
